// ==== rtl/tpf_top.sv ====
// Queue storage and the three-port front end with flags and offset loading.
// Assumes port strobes come from logic on clk_sys; port clocks are not used.
`timescale 1ns/100ps
`default_nettype none

module tpf_queue #(
    parameter int unsigned WIDTH = 36,
    parameter int unsigned DEPTH = 8,
    localparam int unsigned AW   = $clog2(DEPTH)
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             clr,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic      [AW:0]      wr_level,
    output logic      [AW:0]      rd_level
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic [AW:0]      rd_ptr_d;
    logic [AW:0]      wr_s1_q;
    logic [AW:0]      wr_s2_q;
    logic [AW:0]      rd_s1_q;
    logic [AW:0]      rd_s2_q;
    logic             push;
    logic             pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("Queue depth must be a power of two");
    end

    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign wr_level  = wr_ptr_q - rd_s2_q;
    assign rd_level  = wr_s2_q - rd_ptr_q;
    assign in_ready  = (wr_level != (AW + 1)'(DEPTH));
    assign rd_ptr_d  = rd_ptr_q + {{AW{1'b0}}, pop};

    // Storage has no reset; only entries behind the write pointer are read
    always_ff @(posedge clk_sys) begin
        if (ce && push) begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else if (ce) begin
            if (clr) begin
                wr_ptr_q <= '0;
                rd_ptr_q <= '0;
            end else begin
                wr_ptr_q <= wr_ptr_q + {{AW{1'b0}}, push};
                rd_ptr_q <= rd_ptr_d;
            end
        end
    end

    // Two stages stand where the far port's pointer would cross clocks
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_s1_q <= '0;
            wr_s2_q <= '0;
            rd_s1_q <= '0;
            rd_s2_q <= '0;
        end else if (ce) begin
            wr_s1_q <= clr ? '0 : wr_ptr_q;
            wr_s2_q <= clr ? '0 : wr_s1_q;
            rd_s1_q <= clr ? '0 : rd_ptr_q;
            rd_s2_q <= clr ? '0 : rd_s1_q;
        end
    end

    // Look-ahead head register so the front word is ready without a read
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (ce) begin
            out_valid <= ~clr & (rd_ptr_d != wr_s1_q);
            out_data  <= mem_q[rd_ptr_d[AW-1:0]];
        end
    end
endmodule

// What this block does
// - Parallel offsets load through port A writes
// - Queue writes ignored until offsets loaded
// - Serial offset order: Y1, X1, Y2, X2
// - Byte reads drive port B upper bits zero
// - Endian select chooses which half goes first
// - Fall-through: port B ready within three cycles
// - Fall-through: port A ready within three cycles
// - Standard: port B not-empty after first write
// - Standard: port A not-empty after first write
// - Port A not-full after port B frees space
// - Port C not-full after port A frees space
// - Port B empty only after final piece
// - Port C ready drops on final piece only
// - Port B almost-empty falls on last read
// - Port B almost-empty rises after write
// - Port A almost-empty rises after port C write
// - Port A almost-full rises after port B read
// - Port C almost-full falls, rises after read
// - Port C timing counts from final byte
// - Depth is a build option, flags use it
// - Flags keep the same timing in fall-through and standard modes, except output-ready during a master reset
module tpf_top #(
    parameter int unsigned QDEPTH = tpf_pkg::DEPTH_DEF,
    localparam int unsigned OW    = $clog2(QDEPTH)
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        queue1_full_reset_n,
    input  wire logic        queue2_full_reset_n,
    input  wire logic        queue1_partial_reset_n,
    input  wire logic        queue2_partial_reset_n,
    input  wire logic        fall_through_mode,
    input  wire logic        endian_select,
    input  wire logic        serial_offset_mode,
    input  wire logic        serial_offset_enable,
    input  wire logic        serial_offset_data,
    input  wire logic        port_a_select_n,
    input  wire logic        port_a_direction,
    input  wire logic        port_a_mailbox_sel,
    input  wire logic        port_a_enable,
    input  wire logic [35:0] port_a_data_in,
    output logic      [35:0] port_a_data_out,
    output logic             port_a_data_oe,
    output logic             port_a_input_ready,
    output logic             port_a_full_n,
    output logic             port_a_output_ready,
    output logic             port_a_empty_n,
    output logic             port_a_almost_empty_n,
    output logic             port_a_almost_full_n,
    input  wire logic        port_b_select_n,
    input  wire logic        port_b_mailbox_sel,
    input  wire logic        port_b_enable,
    input  wire logic        port_b_byte_width,
    output logic      [17:0] port_b_data,
    output logic             port_b_output_ready,
    output logic             port_b_empty_n,
    output logic             port_b_almost_empty_n,
    input  wire logic        port_c_mailbox_sel,
    input  wire logic        port_c_enable,
    input  wire logic        port_c_byte_width,
    input  wire logic [17:0] port_c_data_in,
    output logic             port_c_input_ready,
    output logic             port_c_full_n,
    output logic             port_c_almost_full_n
);
    localparam logic [OW-1:0] OFS_RST = OW'(tpf_pkg::OFS_DEF);

    tpf_pkg::tpf_cfg_t cfg_q;
    tpf_pkg::tpf_prg_t prg_q;
    logic [OW-1:0] y1_q, x1_q, y2_q, x2_q;
    logic [OW-1:0] ser_q;
    logic [OW-1:0] ser_d;
    logic [OW-1:0] ser_cnt_q;
    logic [OW-1:0] ofs_val;
    logic          ofs_commit;
    logic          prg_done;
    logic          q1_clr, q2_clr, any_master;
    logic          a_wr, a_rd, b_rd, b_last, c_wr, c_last;
    logic [1:0]    b_idx_q, c_idx_q;
    logic [35:0]   c_asm_q, c_asm_d;
    logic [17:0]   b_piece, b_data_q, b_out;
    logic [35:0]   a_data_q;
    logic          q1_in_valid, q1_in_ready, q1_out_valid, q1_pop;
    logic          q2_in_valid, q2_in_ready, q2_out_valid, q2_pop;
    logic [35:0]   q1_out_data, q2_out_data;
    logic [OW:0]   q1_wr_level, q1_rd_level, q2_wr_level, q2_rd_level;
    logic          b_ae_q, a_ae_q, a_af_q, c_af_q;

    if (QDEPTH != 8 && QDEPTH != 1024 && QDEPTH != 4096 && QDEPTH != 16384) begin : g_bad_qdepth
        $error("Queue depth must be 1K, 4K or 16K long words (8 for reduced builds)");
    end

    // Picks a piece of a long word, counting from the end that goes first
    function automatic logic [17:0] piece_sel(input logic [35:0] lw, input logic [1:0] idx,
                                              input logic bytew, input logic be);
        logic [1:0] k;
        k = be ? (bytew ? tpf_pkg::LAST_BYTE - idx : tpf_pkg::LAST_WORD - idx) : idx;
        piece_sel = bytew ? {9'h000, lw[k*9 +: 9]} : lw[k*18 +: 18];
    endfunction

    assign any_master = ~queue1_full_reset_n | ~queue2_full_reset_n;
    assign q1_clr     = ~queue1_full_reset_n | ~queue1_partial_reset_n;
    assign q2_clr     = ~queue2_full_reset_n | ~queue2_partial_reset_n;
    assign prg_done   = (prg_q == tpf_pkg::PRG_DONE);

    // Straps are followed while a master reset is low and held after it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_q <= tpf_pkg::CFG_RST;
        end else if (ce && any_master) begin
            cfg_q <= '{fall_through: fall_through_mode, big_endian: endian_select,
                       serial_prog: serial_offset_mode};
        end
    end

    // Offset loading
    assign a_wr  = ~port_a_select_n & port_a_direction & ~port_a_mailbox_sel & port_a_enable;
    assign a_rd  = ~port_a_select_n & ~port_a_direction & ~port_a_mailbox_sel & port_a_enable;
    assign ser_d = {ser_q[OW-2:0], serial_offset_data};

    always_comb begin
        ofs_commit = 1'b0;
        ofs_val    = port_a_data_in[OW-1:0];
        if (!prg_done) begin
            if (cfg_q.serial_prog) begin
                ofs_commit = serial_offset_enable && (ser_cnt_q == OW'(OW - 1));
                ofs_val    = ser_d;
            end else begin
                ofs_commit = a_wr;
            end
        end
    end

    // Serial bits arrive most significant first; gaps between strobes are fine
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ser_q     <= '0;
            ser_cnt_q <= '0;
        end else if (ce) begin
            if (any_master) begin
                ser_cnt_q <= '0;
            end else if (!prg_done && cfg_q.serial_prog && serial_offset_enable) begin
                ser_q     <= ser_d;
                ser_cnt_q <= ofs_commit ? '0 : ser_cnt_q + OW'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prg_q <= tpf_pkg::PRG_Y1;
            y1_q  <= OFS_RST;
            x1_q  <= OFS_RST;
            y2_q  <= OFS_RST;
            x2_q  <= OFS_RST;
        end else if (ce) begin
            if (any_master) begin
                prg_q <= tpf_pkg::PRG_Y1;
            end else if (ofs_commit) begin
                unique case (prg_q)
                    tpf_pkg::PRG_Y1: begin
                        y1_q  <= ofs_val;
                        prg_q <= tpf_pkg::PRG_X1;
                    end
                    tpf_pkg::PRG_X1: begin
                        x1_q  <= ofs_val;
                        prg_q <= tpf_pkg::PRG_Y2;
                    end
                    tpf_pkg::PRG_Y2: begin
                        y2_q  <= ofs_val;
                        prg_q <= tpf_pkg::PRG_X2;
                    end
                    tpf_pkg::PRG_X2: begin
                        x2_q  <= ofs_val;
                        prg_q <= tpf_pkg::PRG_DONE;
                    end
                    tpf_pkg::PRG_DONE: begin
                        prg_q <= tpf_pkg::PRG_DONE;
                    end
                endcase
            end
        end
    end

    // Queue one: port A to port B
    assign q1_in_valid        = a_wr & prg_done & ~q1_clr;
    assign port_a_input_ready = q1_in_ready & prg_done & ~q1_clr;
    assign port_a_full_n      = port_a_input_ready;

    tpf_queue #(
        .WIDTH (tpf_pkg::LONG_W),
        .DEPTH (QDEPTH)
    ) u_q1 (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .clr       (q1_clr),
        .in_valid  (q1_in_valid),
        .in_ready  (q1_in_ready),
        .in_data   (port_a_data_in),
        .out_valid (q1_out_valid),
        .out_ready (q1_pop),
        .out_data  (q1_out_data),
        .wr_level  (q1_wr_level),
        .rd_level  (q1_rd_level)
    );

    assign b_rd    = ~port_b_select_n & ~port_b_mailbox_sel & port_b_enable & q1_out_valid;
    assign b_last  = b_idx_q == (port_b_byte_width ? tpf_pkg::LAST_BYTE : tpf_pkg::LAST_WORD);
    assign q1_pop  = b_rd & b_last;
    assign b_piece = piece_sel(q1_out_data, b_idx_q, port_b_byte_width, cfg_q.big_endian);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            b_idx_q  <= 2'h0;
            b_data_q <= 18'h00000;
        end else if (ce) begin
            if (q1_clr || q1_pop) begin
                b_idx_q <= 2'h0;
            end else if (b_rd) begin
                b_idx_q <= b_idx_q + 2'h1;
            end
            if (b_rd) begin
                b_data_q <= b_piece;
            end
        end
    end

    // Fall-through shows the head piece at once; standard mode shows it after the read
    assign b_out               = cfg_q.fall_through ? b_piece : b_data_q;
    // Mask at the pin so a word piece left in the register never leaks into byte mode
    assign port_b_data         = {port_b_byte_width ? 9'h000 : b_out[17:9], b_out[8:0]};
    // Fall-through strap pulls ready down at once during a master reset
    assign port_b_output_ready = q1_out_valid & ~(~queue1_full_reset_n & fall_through_mode);
    assign port_b_empty_n      = q1_out_valid;

    // Queue two: port C to port A
    assign c_last             = c_idx_q == (port_c_byte_width ? tpf_pkg::LAST_BYTE : tpf_pkg::LAST_WORD);
    assign port_c_input_ready = q2_in_ready & prg_done & ~q2_clr;
    assign port_c_full_n      = port_c_input_ready;
    assign c_wr               = port_c_enable & ~port_c_mailbox_sel & port_c_input_ready;
    assign q2_in_valid        = c_wr & c_last;

    always_comb begin
        c_asm_d = c_asm_q;
        if (port_c_byte_width && cfg_q.big_endian) begin
            c_asm_d = {c_asm_q[26:0], port_c_data_in[8:0]};
        end else if (port_c_byte_width) begin
            c_asm_d = {port_c_data_in[8:0], c_asm_q[35:9]};
        end else if (cfg_q.big_endian) begin
            c_asm_d = {c_asm_q[17:0], port_c_data_in};
        end else begin
            c_asm_d = {port_c_data_in, c_asm_q[35:18]};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            c_idx_q <= 2'h0;
            c_asm_q <= 36'h000000000;
        end else if (ce) begin
            if (q2_clr || q2_in_valid) begin
                c_idx_q <= 2'h0;
            end else if (c_wr) begin
                c_idx_q <= c_idx_q + 2'h1;
            end
            if (c_wr) begin
                c_asm_q <= c_asm_d;
            end
        end
    end

    tpf_queue #(
        .WIDTH (tpf_pkg::LONG_W),
        .DEPTH (QDEPTH)
    ) u_q2 (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .clr       (q2_clr),
        .in_valid  (q2_in_valid),
        .in_ready  (q2_in_ready),
        .in_data   (c_asm_d),
        .out_valid (q2_out_valid),
        .out_ready (q2_pop),
        .out_data  (q2_out_data),
        .wr_level  (q2_wr_level),
        .rd_level  (q2_rd_level)
    );

    assign q2_pop              = a_rd & q2_out_valid;
    assign port_a_output_ready = q2_out_valid & ~(~queue2_full_reset_n & fall_through_mode);
    assign port_a_empty_n      = q2_out_valid;
    assign port_a_data_oe      = ~port_a_select_n & ~port_a_direction;
    assign port_a_data_out     = cfg_q.fall_through ? q2_out_data : a_data_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            a_data_q <= 36'h000000000;
        end else if (ce && q2_pop) begin
            a_data_q <= q2_out_data;
        end
    end

    // Almost flags are registered, so each lags its level by one cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            b_ae_q <= 1'b0;
            a_ae_q <= 1'b0;
            a_af_q <= 1'b1;
            c_af_q <= 1'b1;
        end else if (ce) begin
            b_ae_q <= q1_rd_level > {1'b0, x1_q};
            a_ae_q <= q2_rd_level > {1'b0, x2_q};
            a_af_q <= ((OW + 1)'(QDEPTH) - q1_wr_level) > {1'b0, y1_q};
            c_af_q <= ((OW + 1)'(QDEPTH) - q2_wr_level) > {1'b0, y2_q};
        end
    end

    assign port_b_almost_empty_n = b_ae_q;
    assign port_a_almost_empty_n = a_ae_q;
    assign port_a_almost_full_n  = a_af_q;
    assign port_c_almost_full_n  = c_af_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    ignore_early_a: assert property ((a_wr && !port_a_input_ready && !q1_clr && ce)
        |=> q1_wr_level <= $past(q1_wr_level)) else $error("Write taken before ready");
    byte_zero_a: assert property (port_b_byte_width |-> port_b_data[17:9] == 9'h000)
        else $error("Upper port B bits not zero in byte mode");
    endian_c_a: assert property ((q2_in_valid && !port_c_byte_width) |->
        (cfg_q.big_endian ? c_asm_d[17:0] : c_asm_d[35:18]) == port_c_data_in)
        else $error("Long word halves in wrong order");
    fall_b_a: assert property (disable iff (rst || q1_clr || !ce)
        (q1_in_valid && q1_in_ready && q1_rd_level == '0 && !port_b_output_ready)
        |-> ##[1:3] port_b_output_ready) else $error("Port B ready late");
    fall_a_a: assert property (disable iff (rst || q2_clr || !ce)
        (q2_in_valid && q2_in_ready && q2_rd_level == '0 && !port_a_output_ready)
        |-> ##[1:3] port_a_output_ready) else $error("Port A ready late");
    free_a_a: assert property (disable iff (rst || q1_clr || !ce)
        (q1_pop && !q1_in_ready && prg_done) |-> ##[1:3] port_a_input_ready)
        else $error("Port A full flag stuck");
    free_c_a: assert property (disable iff (rst || q2_clr || !ce)
        (q2_pop && !q2_in_ready && prg_done) |-> ##[1:3] port_c_input_ready)
        else $error("Port C full flag stuck");
    empty_last_a: assert property (disable iff (rst || q1_clr)
        $fell(port_b_output_ready) |-> $past(q1_pop)) else $error("Port B empty before last piece");
    ready_last_a: assert property (disable iff (rst || q2_clr || !prg_done)
        $fell(port_c_input_ready) |-> $past(q2_in_valid)) else $error("Port C ready fell mid word");
    ae_fall_b_a: assert property (disable iff (rst || q1_clr)
        ($fell(port_b_almost_empty_n) && !$past(q1_clr) && !$past(q1_clr, 2))
        |-> $past(q1_pop, 2)) else $error("Almost empty fell without read");

    fall_through_mode_cover: cover property (cfg_q.fall_through && $rose(port_b_output_ready));
    byte_pop_cover: cover property (port_b_byte_width && q1_pop);
    prog_cover: cover property ($rose(prg_done));
    c_byte_cover: cover property (port_c_byte_width && q2_in_valid);
endmodule

`default_nettype wire

// ==== common/tpf_pkg.sv ====
// Shared constants and types for the three-port queue pair.
// Assumes every port runs on the one system clock.
package tpf_pkg;
    localparam int unsigned LONG_W    = 36;
    localparam int unsigned WORD_W    = 18;
    localparam int unsigned BYTE_W    = 9;
    localparam int unsigned DEPTH_DEF = 1024;
    localparam int unsigned OFS_DEF   = 8;
    localparam logic [1:0]  LAST_WORD = 2'h1;
    localparam logic [1:0]  LAST_BYTE = 2'h3;

    typedef struct packed {
        logic fall_through;
        logic big_endian;
        logic serial_prog;
    } tpf_cfg_t;

    localparam tpf_cfg_t CFG_RST = 3'h0;

    typedef enum logic [2:0] {
        PRG_Y1   = 3'h0,
        PRG_X1   = 3'h1,
        PRG_Y2   = 3'h3,
        PRG_X2   = 3'h2,
        PRG_DONE = 3'h6
    } tpf_prg_t;
endpackage

// ==== bench/tpf_c_src.sv ====
// Port C source model: a bus master that writes long words as 18-bit or 9-bit pieces.
// Assumes send is called just after a rising edge of clk_sys.
`timescale 1ns/100ps
`default_nettype none
module tpf_c_src (
    input  wire logic        clk_sys,
    input  wire logic        byte_w,
    input  wire logic        big_end,
    input  wire logic        ready,
    output logic             en,
    output logic      [17:0] data
);
    // Counts pieces that never saw ready; the bench checks it stays zero
    int n_late;

    initial begin
        en     = 1'b0;
        data   = 18'h00000;
        n_late = 0;
    end
    // Released data shows the inverse of the last piece so a stale value never matches
    task automatic send(input logic [35:0] lw);
        int   n;
        int   k;
        int   t;
        logic r;
        n = byte_w ? 4 : 2;
        for (int i = 0; i < n; i++) begin
            k = big_end ? n - 1 - i : i;
            data = byte_w ? {9'h000, lw[k*9 +: 9]} : lw[k*18 +: 18];
            en = 1'b1;
            r = 1'b0;
            t = 0;
            while (!r && t < 50) begin
                r = (ready === 1'b1);
                @(posedge clk_sys);
                #1;
                t++;
            end
            if (!r) begin
                n_late++;
            end
        end
        en   = 1'b0;
        data = ~data;
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_tri_port_fifo_flag_sync.sv ====
// Bench for the three-port queue pair: port A/B tasks, port C through the source model.
// Assumes tpf_top built with QDEPTH 8 and mailbox selects idle.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_tri_port_fifo_flag_sync;
    logic        clk_sys, rst, fr1_n, fr2_n, pr1_n, pr2_n, ft, be, sm, sen, sd;
    logic        a_sel_n, a_dir, a_en, a_ir, a_or, a_ae, a_af;
    logic        b_sel_n, b_en, b_bw, b_or, b_ae, c_bw, c_en, c_ir, c_af;
    logic [35:0] a_din, a_dout, w;
    logic [17:0] b_dat, c_din;
    int          n_errors, check_count;

    tpf_top #(.QDEPTH(8)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .queue1_full_reset_n(fr1_n), .queue2_full_reset_n(fr2_n),
        .queue1_partial_reset_n(pr1_n), .queue2_partial_reset_n(pr2_n), .fall_through_mode(ft),
        .endian_select(be), .serial_offset_mode(sm), .serial_offset_enable(sen), .serial_offset_data(sd),
        .port_a_select_n(a_sel_n), .port_a_direction(a_dir), .port_a_mailbox_sel(1'b0), .port_a_enable(a_en),
        .port_a_data_in(a_din), .port_a_data_out(a_dout), .port_a_data_oe(), .port_a_input_ready(a_ir),
        .port_a_full_n(), .port_a_output_ready(a_or), .port_a_empty_n(), .port_a_almost_empty_n(a_ae),
        .port_a_almost_full_n(a_af), .port_b_select_n(b_sel_n), .port_b_mailbox_sel(1'b0), .port_b_enable(b_en),
        .port_b_byte_width(b_bw), .port_b_data(b_dat), .port_b_output_ready(b_or), .port_b_empty_n(),
        .port_b_almost_empty_n(b_ae), .port_c_mailbox_sel(1'b0), .port_c_enable(c_en),
        .port_c_byte_width(c_bw), .port_c_data_in(c_din), .port_c_input_ready(c_ir), .port_c_full_n(),
        .port_c_almost_full_n(c_af));

    tpf_c_src u_src (.clk_sys(clk_sys), .byte_w(c_bw), .big_end(be), .ready(c_ir), .en(c_en), .data(c_din));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return b_or;
            1: return a_or;
            2: return a_ir;
            3: return b_ae;
            default: return a_af;
        endcase
    endfunction

    // Bounded wait that doubles as a latency check: lim is the number of edges allowed
    task automatic wait_hi(input int s, input int lim);
        int k;
        k = 0;
        check_count++;
        while (pick(s) !== 1'b1) begin
            if (k == lim) begin
                n_errors++;
                $display("unexpected at %0t: flag %h got %h expected 1", $time, s, pick(s));
                report_and_stop();
            end
            tick();
            k++;
        end
    endtask

    // Strobe stays up so back-to-back writes need no gap; a_idle drops it
    task automatic a_put(input logic [35:0] d);
        a_sel_n = 1'b0;
        a_dir   = 1'b1;
        a_en    = 1'b1;
        a_din   = d;
        tick();
    endtask

    task automatic a_idle();
        a_en    = 1'b0;
        a_sel_n = 1'b1;
        a_din   = ~a_din;
        tick();
    endtask

    task automatic a_wr(input logic [35:0] d);
        // A held strobe would replay the old word the moment ready returns
        if (a_ir !== 1'b1) a_en = 1'b0;
        wait_hi(2, 20);
        a_put(d);
    endtask

    task automatic rd_lw(input logic [35:0] lw);
        int          n;
        int          k;
        logic [17:0] e;
        n = b_bw ? 4 : 2;
        for (int i = 0; i < n; i++) begin
            k = be ? n - 1 - i : i;
            e = b_bw ? {9'h000, lw[k*9 +: 9]} : lw[k*18 +: 18];
            wait_hi(0, 20);
            if (ft) `CHK(b_dat, e)
            b_sel_n = 1'b0;
            b_en    = 1'b1;
            tick();
            if (!ft) `CHK(b_dat, e)
            if (i < n - 1) `CHK(b_or, 1'b1)
        end
        b_en    = 1'b0;
        b_sel_n = 1'b1;
        tick();
    endtask

    initial begin
        n_errors = 0;
        check_count = 0;
        rst = 1'b1;
        fr1_n = 1'b0;
        fr2_n = 1'b0;
        pr1_n = 1'b1;
        pr2_n = 1'b1;
        {ft, be, sm, sen, sd} = 5'h08;
        {a_sel_n, a_dir, a_en, b_sel_n, b_en, b_bw, c_bw} = 7'h48;
        a_din = 36'h000000000;
        w = 36'h000000000;
        repeat (10) @(posedge clk_sys);
        #1 rst = 1'b0;
        tick();
        `CHK(a_ir, 1'b0)
        `CHK(b_ae, 1'b0)
        fr1_n = 1'b1;
        fr2_n = 1'b1;
        tick();
        // Offsets Y1=2, X1=1, Y2=2, X2=0 with a gap in the middle
        a_put(36'h000000002);
        a_put(36'h000000001);
        a_idle();
        `CHK(a_ir, 1'b0)
        a_put(36'h000000002);
        a_put(36'h000000000);
        a_idle();
        wait_hi(2, 2);
        $display("test offsets done");
        a_wr(36'h900000000);
        a_idle();
        wait_hi(0, 2);
        for (int i = 1; i < 8; i++) begin
            a_wr(36'h900000000 + i);
            if (i == 1) begin
                a_idle();
                wait_hi(3, 3);
            end
        end
        a_idle();
        `CHK(a_ir, 1'b0)
        rd_lw(36'h900000000);
        wait_hi(2, 2);
        `CHK(a_af, 1'b0)
        rd_lw(36'h900000001);
        rd_lw(36'h900000002);
        wait_hi(4, 3);
        for (int i = 3; i < 8; i++) rd_lw(36'h900000000 + i);
        `CHK(b_ae, 1'b0)
        `CHK(b_or, 1'b0)
        $display("test queue1 word done");
        b_bw = 1'b1;
        w = 36'hA5C3F0E71;
        a_wr(w);
        a_idle();
        rd_lw(w);
        `CHK(b_or, 1'b0)
        $display("test byte read done");
        c_bw = 1'b1;
        w = 36'h3C5A961E8;
        u_src.send(w);
        `CHK(u_src.n_late, 0)
        wait_hi(1, 3);
        tick();
        `CHK(a_ae, 1'b1)
        a_sel_n = 1'b0;
        a_dir = 1'b0;
        a_en = 1'b1;
        tick();
        `CHK(a_dout, w)
        a_idle();
        $display("test port c done");
        // Master reset into fall-through, serial offsets Y1=7, X1=0, Y2=5, X2=2
        fr1_n = 1'b0;
        {ft, be, sm, b_bw} = 4'hA;
        tick();
        tick();
        fr1_n = 1'b1;
        tick();
        for (int i = 11; i >= 0; i--) begin
            sd = 1'(12'hE2A >> i);
            sen = 1'b1;
            tick();
            if (i == 6) begin
                sen = 1'b0;
                tick();
            end
        end
        sen = 1'b0;
        w = 36'h123456789;
        a_wr(w);
        a_idle();
        wait_hi(0, 2);
        tick();
        tick();
        `CHK(b_ae, 1'b1)
        `CHK(a_af, 1'b0)
        rd_lw(w);
        // Three more long words leave five free, at the Y2 threshold
        repeat (3) begin
            u_src.send(w);
            tick();
        end
        `CHK(c_af, 1'b0)
        `CHK(u_src.n_late, 0)
        $display("test fall-through done");
        report_and_stop();
    end
endmodule
`default_nettype wire
